// file: logic/lit_sub_exec.sv
// Our own choices: the address map and register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
`include "lit_sub_consts.svh"

module lit_sub_exec #(
    parameter int unsigned CNT_W = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire lit_sub_pkg::wb_req_s wb_req_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire lit_sub_pkg::instr_s instr_i,
    output logic [7:0] work_o,
    output var lit_sub_pkg::flags_s flags_o,
    output logic done_o,
    output logic illegal_o
);
    import lit_sub_pkg::*;

    // Address match used by every register decode
    function automatic logic adr_is(input logic [7:0] a,
                                    input logic [7:0] ofs);
        return a == ofs;
    endfunction

    // State
    logic [7:0] work_q;
    logic [7:0] work_d;
    flags_s flags_q;
    flags_s flags_d;
    logic port_en_q;
    logic [CNT_W-1:0] count_q;
    logic pend_q;
    logic [15:0] pend_word_q;
    logic [15:0] last_q;
    logic ack_q;
    logic [31:0] dat_q;
    logic done_q;
    logic illegal_q;

    // Bus decode; a write commits at the edge where ack is high
    wire logic bus_hit = wb_req_i.cyc & wb_req_i.stb;
    wire logic bus_wr = bus_hit & wb_req_i.we & ack_q;
    wire logic hit_work = adr_is(wb_req_i.adr, `OFS_WORK);
    wire logic hit_flags = adr_is(wb_req_i.adr, `OFS_FLAGS);
    wire logic hit_instr = adr_is(wb_req_i.adr, `OFS_INSTR);
    wire logic hit_ctrl = adr_is(wb_req_i.adr, `OFS_CTRL);
    wire logic hit_count = adr_is(wb_req_i.adr, `OFS_COUNT);
    wire logic wr_work = bus_wr & hit_work & wb_req_i.sel[0];
    wire logic wr_flags = bus_wr & hit_flags & wb_req_i.sel[0];
    wire logic wr_instr = bus_wr & hit_instr & (&wb_req_i.sel[1:0]);
    wire logic wr_ctrl = bus_wr & hit_ctrl & wb_req_i.sel[0];

    // A second instruction write waits while one is still queued
    wire logic stall = pend_q & hit_instr & wb_req_i.we;
    wire logic ack_d = bus_hit & ~ack_q & ~stall;

    // Instruction source: decoder port first, queued bus word next
    wire logic port_go = instr_i.valid & port_en_q;
    wire logic cur_valid = port_go | pend_q;
    wire logic [15:0] cur_word = port_go ? instr_i.word : pend_word_q;
    wire logic pend_d = wr_instr | (pend_q & port_go);

    // Opcode check on the upper byte, literal in the low byte
    wire logic op_match = cur_word[15:8] == `OPC_LIT_MINUS_W;
    wire logic fire = cur_valid & op_match;
    wire logic bad = cur_valid & ~op_match;
    wire logic [7:0] lit = cur_word[7:0];

    // Nine-bit difference keeps the borrow in the top bit
    wire logic [8:0] diff9 = {1'b0, lit} - {1'b0, work_q};
    wire logic [4:0] nib5 = {1'b0, lit[3:0]} - {1'b0, work_q[3:0]};
    wire logic [7:0] res = diff9[7:0];

    // New flag values from the computed difference
    wire logic n_new = res[7];
    wire logic z_new = res == 8'h00;
    wire logic c_new = ~diff9[8];
    wire logic dc_new = ~nib5[4];
    wire logic ov_new = (lit[7] ^ work_q[7]) & (res[7] ^ lit[7]);
    wire flags_s flags_new = '{n: n_new, ov: ov_new, z: z_new,
                               dc: dc_new, c: c_new};

    // Next state; an executing instruction wins over a bus write
    assign work_d = fire ? res : (wr_work ? wb_req_i.dat[7:0] : work_q);
    assign flags_d = fire ? flags_new :
                     (wr_flags ? flags_s'(wb_req_i.dat[4:0]) : flags_q);

    // Read multiplexer; unmapped offsets read as zero
    wire logic [31:0] rd_ctrl = {30'h0, pend_q, port_en_q};
    wire logic [31:0] rd_word =
        hit_work ? {24'h0, work_q} :
        hit_flags ? {27'h0, flags_q} :
        hit_instr ? {16'h0, last_q} :
        hit_ctrl ? rd_ctrl :
        hit_count ? 32'(count_q) : 32'h0;

    // Working register and flags
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            work_q <= `RST_WORK;
            flags_q <= flags_s'(`RST_FLAGS);
        end else begin
            work_q <= work_d;
            flags_q <= flags_d;
        end
    end

    // Queued bus instruction and last taken word, unknown opcodes included
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_q <= 1'b0;
            pend_word_q <= 16'h0;
            last_q <= 16'h0;
        end else begin
            pend_q <= pend_d;
            if (wr_instr) begin
                pend_word_q <= wb_req_i.dat[15:0];
            end
            if (cur_valid) begin
                last_q <= cur_word;
            end
        end
    end

    // Control and execution counter
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_en_q <= `RST_PORT_EN;
            count_q <= '0;
        end else begin
            if (wr_ctrl) begin
                port_en_q <= wb_req_i.dat[`CTRL_PORT_EN];
            end
            if (fire) begin
                count_q <= count_q + 1'b1;
            end
        end
    end

    // Completion pulses, one cycle after the instruction is taken
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_q <= 1'b0;
            illegal_q <= 1'b0;
        end else begin
            done_q <= fire;
            illegal_q <= bad;
        end
    end

    // Bus answer: ack one cycle after the request unless a stalled instruction write, dropped after one
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0;
        end else begin
            ack_q <= ack_d;
            dat_q <= ack_d ? rd_word : 32'h0;
        end
    end

    // Outputs straight from flip-flops
    assign work_o = work_q;
    assign flags_o = flags_q;
    assign done_o = done_q;
    assign illegal_o = illegal_q;
    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    // Checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_result_value: assert property (
        fire |=> work_q == 8'($past(lit) - $past(work_q)))
        else $error("working register not literal minus working");

    a_carry_borrow: assert property (
        fire |=> flags_q.c == ($past(lit) >= $past(work_q)))
        else $error("carry does not match inverted borrow");

    a_neg_wrap: assert property (
        fire && (lit < work_q) |=> flags_q.n == work_q[7]
            && !flags_q.z && !flags_q.c && work_q != 8'h00)
        else $error("negative result flags wrong");

    a_zero_flag: assert property (
        fire && (lit == work_q) |=> flags_q.z && flags_q.c
            && !flags_q.n && !flags_q.ov && flags_q.dc)
        else $error("zero result flags wrong");

    a_flags_hold: assert property (
        !fire && !wr_flags |=> $stable(flags_q))
        else $error("flags changed without cause");

    a_one_cycle: assert property (
        fire |=> done_o ##1 !done_o || $past(fire))
        else $error("completion pulse not one cycle after");

    a_illegal_hold: assert property (
        bad && !wr_work |=> $stable(work_q) && illegal_o)
        else $error("unknown opcode altered working register");

    a_ack_pulse: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    // Flag values tied to the stored difference and the operands
    a_neg_flag: assert property (
        fire |=> flags_q.n == work_q[7])
        else $error("negative flag not result sign");

    a_zero_exact: assert property (
        fire |=> flags_q.z == (work_q == 8'h00))
        else $error("zero flag not result zero");

    a_digit_carry: assert property (
        fire |=> flags_q.dc == ($past(lit[3:0]) >= $past(work_q[3:0])))
        else $error("digit carry not low nibble no-borrow");

    a_overflow_flag: assert property (
        fire |=> flags_q.ov == (($past(lit[7]) != $past(work_q[7]))
            && (work_q[7] != $past(lit[7]))))
        else $error("overflow flag wrong");

    // Working register and flags move only on an instruction or a bus write
    a_work_hold: assert property (
        !fire && !wr_work |=> $stable(work_q))
        else $error("working register changed without cause");

    a_bus_work: assert property (
        wr_work && !fire |=> work_q == $past(wb_req_i.dat[7:0]))
        else $error("bus write to working register lost");

    a_bus_flags: assert property (
        wr_flags && !fire |=> flags_q == $past(wb_req_i.dat[4:0]))
        else $error("bus write to flags lost");

    a_exec_wins: assert property (
        fire && wr_work |=> work_q == 8'($past(lit) - $past(work_q)))
        else $error("bus write won over execution");

    // Completion pulses and their causes
    a_illegal_pulse: assert property (
        bad |=> illegal_o && !done_o)
        else $error("unknown opcode pulse missing");

    a_done_cause: assert property (
        done_o |-> $past(fire))
        else $error("completion pulse without execution");

    a_illegal_cause: assert property (
        illegal_o |-> $past(bad))
        else $error("unknown opcode pulse without cause");

    a_port_gate: assert property (
        instr_i.valid && !port_en_q && !pend_q |=> !done_o && !illegal_o)
        else $error("disabled port still executed");

    a_last_word: assert property (
        cur_valid |=> last_q == $past(cur_word))
        else $error("last instruction word not kept");

    // Execution counter
    a_count_step: assert property (
        fire |=> count_q == $past(count_q) + 1'b1)
        else $error("counter did not step on execution");

    a_count_hold: assert property (
        !fire |=> $stable(count_q))
        else $error("counter moved without execution");

    // Queued bus instruction
    a_pend_runs: assert property (
        pend_q && !port_go |=> !pend_q)
        else $error("queued instruction not run");

    a_pend_waits: assert property (
        pend_q && port_go |=> pend_q)
        else $error("queued instruction dropped");

    // Bus handshake and read data
    a_ack_answer: assert property (
        bus_hit && !ack_q && !stall |=> wb_ack_o)
        else $error("ack missing one cycle after request");

    a_ack_cause: assert property (
        wb_ack_o |-> $past(bus_hit))
        else $error("ack without request");

    a_stall_hold: assert property (
        stall |=> !wb_ack_o)
        else $error("queued instruction write acked early");

    a_dat_idle: assert property (
        !wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");

    a_read_work: assert property (
        bus_hit && hit_work && !wb_req_i.we && !ack_q
            |=> wb_dat_o == {24'h0, $past(work_q)})
        else $error("working register read data wrong");

endmodule

`default_nettype wire

// file: logic/lit_sub_consts.svh
`ifndef LIT_SUB_CONSTS_SVH
`define LIT_SUB_CONSTS_SVH

// Register byte offsets on the bus
`define OFS_WORK 8'h00
`define OFS_FLAGS 8'h04
`define OFS_INSTR 8'h08
`define OFS_CTRL 8'h0c
`define OFS_COUNT 8'h10

// Control register field positions
`define CTRL_PORT_EN 0
`define CTRL_PEND 1

// Reset values
`define RST_WORK 8'h00
`define RST_FLAGS 5'h00
`define RST_PORT_EN 1'b1

// Opcode byte of the literal-minus-working operation
`define OPC_LIT_MINUS_W 8'h08

// Cycles from an accepted instruction to its written result
`define EXEC_CYCLES 1

`endif

// file: logic/lit_sub_pkg.sv
package lit_sub_pkg;

    // Status flags; bit order gives c=0, dc=1, z=2, ov=3, n=4
    typedef struct packed {
        logic n;
        logic ov;
        logic z;
        logic dc;
        logic c;
    } flags_s;

    // Classic Wishbone request from the master
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_s;

    // Instruction word from the decoder
    typedef struct packed {
        logic valid;
        logic [15:0] word;
    } instr_s;

endpackage

// file: verif/decoder_model.sv
`timescale 1ns/10ps
`default_nettype none
// Decoder stand-in: one instruction word offered per send pulse
module decoder_model (
    input wire logic clk_i,
    input wire logic send_i,
    input wire logic [15:0] word_i,
    output var lit_sub_pkg::instr_s instr_o
);
    import lit_sub_pkg::*;
    // Word is meaningful only with valid; idle word keeps toggling
    always_ff @(posedge clk_i) begin
        instr_o.valid <= send_i;
        instr_o.word <= send_i ? word_i : ~instr_o.word;
    end
endmodule
`default_nettype wire

// file: verif/subtract_w_from_literal_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "lit_sub_consts.svh"
module subtract_w_from_literal_tb;
    import lit_sub_pkg::*;
    logic clk_i, rst_i, send, done_o, illegal_o, wb_ack_o;
    logic [15:0] word;
    logic [31:0] wb_dat_o, q;
    logic [7:0] work_o, wm;
    wb_req_s req;
    instr_s instr;
    flags_s flags_o;
    int errors = 0, total_checks = 0;
    logic [7:0] ks [7] = '{8'h02, 8'h02, 8'h02, 8'h80, 8'h10, 8'hff, 8'h00};
    logic [7:0] ws [7] = '{8'h01, 8'h02, 8'h03, 8'h01, 8'h01, 8'h00, 8'hff};
    lit_sub_exec dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .instr_i(instr),
        .work_o(work_o), .flags_o(flags_o), .done_o(done_o),
        .illegal_o(illegal_o));
    decoder_model dec (.clk_i(clk_i), .send_i(send), .word_i(word),
        .instr_o(instr));
    // Free-running 100 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // One classic Wishbone cycle, held until ack is sampled
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] rd);
        int n;
        @(posedge clk_i);
        req <= '{1'b1, 1'b1, we, a, 4'hf, d};
        for (n = 0; n < 50; n++) begin
            @(posedge clk_i);
            if (wb_ack_o === 1'b1) break;
        end
        if (n == 50) begin
            errors++;
            end_sim();
        end
        rd = wb_dat_o;
        req <= '0;
    endtask
    // Offer a word and wait for its completion pulse
    task automatic run(input logic [15:0] wd);
        int n;
        @(posedge clk_i);
        send <= 1'b1;
        word <= wd;
        @(posedge clk_i);
        send <= 1'b0;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_i);
            if (done_o === 1'b1 || illegal_o === 1'b1) break;
        end
        if (n == 20) begin
            errors++;
            end_sim();
        end
    endtask
    function automatic flags_s ef(input logic [7:0] k, input logic [7:0] w);
        logic [7:0] r;
        r = k - w;
        return '{r[7], (k[7] != w[7]) && (r[7] != k[7]), r == 8'h00,
                 k[3:0] >= w[3:0], k >= w};
    endfunction
    // Run literal-minus-working on W and compare result and flags
    task automatic sub_chk(input logic [7:0] k);
        flags_s f;
        f = ef(k, wm);
        run({`OPC_LIT_MINUS_W, k});
        wm = k - wm;
        chk(work_o, wm);
        chk(flags_o, f);
    endtask
    // Main sequence
    initial begin
        rst_i = 1'b1;
        req = '0;
        send = 1'b0;
        word = 16'h0000;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk(work_o, 8'h00);
        chk(flags_o, 5'h00);
        for (int i = 0; i < 7; i++) begin
            wb(1'b1, `OFS_WORK, {24'h0, ws[i]}, q);
            wm = ws[i];
            sub_chk(ks[i]);
            $display("case %0d done", i);
        end
        sub_chk(8'h00);
        sub_chk(8'h7f);
        run(16'h0902);
        chk(illegal_o, 1'b1);
        chk(work_o, wm);
        wb(1'b0, `OFS_WORK, 32'h0, q);
        chk(q, {24'h0, wm});
        wb(1'b0, 8'h20, 32'h0, q);
        chk(q, 32'h0);
        // Flags written and read back over the bus
        wb(1'b1, `OFS_FLAGS, 32'h15, q);
        wb(1'b0, `OFS_FLAGS, 32'h0, q);
        chk(q, 32'h15);
        chk(flags_o, 5'h15);
        wb(1'b0, `OFS_COUNT, 32'h0, q);
        chk(q, 32'h9);
        // Two queued bus instructions, the first run before the second is written
        wb(1'b1, `OFS_WORK, 32'h05, q);
        wb(1'b1, `OFS_INSTR, {16'h0, `OPC_LIT_MINUS_W, 8'h20}, q);
        wb(1'b1, `OFS_INSTR, {16'h0, `OPC_LIT_MINUS_W, 8'h01}, q);
        wb(1'b0, `OFS_WORK, 32'h0, q);
        chk(q, 32'he6);
        chk(flags_o, ef(8'h01, 8'h1b));
        wb(1'b0, `OFS_INSTR, 32'h0, q);
        chk(q, 32'h0801);
        wm = 8'he6;
        // Port disabled: the offered word is ignored
        wb(1'b1, `OFS_CTRL, 32'h0, q);
        @(posedge clk_i);
        send <= 1'b1;
        word <= {`OPC_LIT_MINUS_W, 8'h00};
        @(posedge clk_i);
        send <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk(work_o, wm);
        wb(1'b1, `OFS_CTRL, 32'h1, q);
        wb(1'b0, `OFS_COUNT, 32'h0, q);
        chk(q, 32'hb);
        $display("bus and opcode tests done");
        // Reset in mid-run
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk(work_o, 8'h00);
        chk(flags_o, 5'h00);
        wb(1'b0, `OFS_CTRL, 32'h0, q);
        chk(q, 32'h1);
        wm = 8'h00;
        sub_chk(8'h05);
        $display("reset test done");
        end_sim();
    end
endmodule
`default_nettype wire
